// ==== rtl/dcps_pkg.sv ====
// Constants shared by the DAC clear and pin-share block.
package dcps_pkg;

  // ****************************************************************
  // Sizes.
  // ****************************************************************
  localparam int DCPS_NUM_DAC = 12;  // Number of DAC channels.
  localparam int DCPS_DAC_W = 12;  // Width of one DAC code.
  localparam int DCPS_NUM_IO = 8;  // Number of general-purpose pins.
  localparam int DCPS_AW = 8;  // APB address bits decoded.
  localparam int DCPS_DW = 32;  // APB data width.

  // ****************************************************************
  // Register byte offsets.
  // ****************************************************************
  localparam logic [7:0] DCPS_OFF_CTRL = 8'h00;  // Sensor channel enables.
  localparam logic [7:0] DCPS_OFF_IO_OUT = 8'h04;  // Open-drain output levels.
  localparam logic [7:0] DCPS_OFF_IO_IN = 8'h08;  // Sampled pin levels.
  localparam logic [7:0] DCPS_OFF_CLR_MASK = 8'h0C;  // Channels tied to clear.
  localparam logic [7:0] DCPS_OFF_SYNC_SEL = 8'h10;  // Synchronous-load bits.
  localparam logic [7:0] DCPS_OFF_LOAD = 8'h14;  // Load strobe, write only.
  localparam logic [7:0] DCPS_OFF_CLR_CODE = 8'h18;  // Predefined clear code.
  localparam logic [7:0] DCPS_OFF_STATUS = 8'h1C;  // Clear state status.
  localparam logic [7:0] DCPS_OFF_HOLD0 = 8'h40;  // First holding register.

  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int DCPS_CTRL_S1_EN = 0;  // Remote sensor one enable.
  localparam int DCPS_CTRL_S2_EN = 1;  // Remote sensor two enable.
  localparam int DCPS_STAT_CLR = 0;  // Clear state active.
  localparam int DCPS_S1_PIN_LO = 4;  // Sensor one uses pins four and five.
  localparam int DCPS_S2_PIN_LO = 6;  // Sensor two uses pins six and seven.

  // ****************************************************************
  // Reset values.
  // ****************************************************************
  localparam logic [1:0] DCPS_CTRL_RST = 2'h0;  // Sensors off, pins are I/O.
  localparam logic [7:0] DCPS_IO_OUT_RST = 8'hFF;  // All pins released.
  localparam logic [11:0] DCPS_CLR_MASK_RST = 12'hFFF;  // All channels tied.
  localparam logic [11:0] DCPS_SYNC_SEL_RST = 12'h000;  // Immediate update.
  localparam logic [11:0] DCPS_CLR_CODE_RST = 12'h000;  // Clear to zero scale.
  localparam logic [11:0] DCPS_HOLD_RST = 12'h000;  // Holding data at reset.

endpackage : dcps_pkg

// ==== rtl/dcps_sync.sv ====
// Two-flop level synchroniser.
`timescale 1ns/1ns
`default_nettype none
module dcps_sync #(
  parameter logic RST_VAL = 1'b1
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_in,
  // Level in and out.
  input wire logic d_in,
  output logic q_out
);

  logic meta_q;  // First stage, read only by the second stage.

  // Two stages; the first may go metastable and is never used elsewhere.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_q <= RST_VAL;
      q_out <= RST_VAL;
    end else begin
      meta_q <= d_in;
      q_out <= meta_q;
    end
  end

endmodule : dcps_sync
`default_nettype wire

// ==== rtl/dcps_mem.sv ====
// Holding data registers for the DAC channels.
`timescale 1ns/1ns
`default_nettype none
module dcps_mem #(
  parameter int WORDS = 12,
  parameter int W = 12,
  parameter logic [11:0] RST_VAL = 12'h000,
  localparam int AW = $clog2(WORDS)
) (
  // Clock and resets.
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic srst_in,
  // Write port.
  input wire logic we_in,
  input wire logic [AW-1:0] waddr_in,
  input wire logic [W-1:0] wdata_in,
  // Registered read port.
  input wire logic [AW-1:0] raddr_in,
  output logic [W-1:0] rdata_out,
  // Every word at once, for a whole-group latch reload.
  output logic [WORDS*W-1:0] words_out
);

  logic [W-1:0] mem_q [WORDS];  // Storage words.

  // Storage; a synchronous reset clears it like the asynchronous one.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < WORDS; i++) mem_q[i] <= RST_VAL[W-1:0];
    end else if (srst_in) begin
      for (int i = 0; i < WORDS; i++) mem_q[i] <= RST_VAL[W-1:0];
    end else if (we_in) begin
      mem_q[waddr_in] <= wdata_in;
    end
  end

  // Read data comes out of a register, one cycle after the address.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= '0;
    end else begin
      rdata_out <= mem_q[raddr_in];
    end
  end

  // Flat view of all words.
  for (genvar g = 0; g < WORDS; g++) begin : g_flat
    assign words_out[g*W +: W] = mem_q[g];
  end

endmodule : dcps_mem
`default_nettype wire

// ==== rtl/dcps_top.sv ====
// DAC group clear control and shared sensor/general-purpose pin logic.
//
// Contract
// - General pins are open-drain, pull low only.
// - Clear low puts assigned channels in clear.
// - Entering clear loads latch with clear code.
// - Clear never alters holding data registers.
// - Leaving clear reloads latch regardless sync bit.
// - Clear high means normal data and load path.
// - Sensor two pins become I/O six, seven.
// - Sensor one negative pin becomes I/O four; the code gives sensor one both I/O four and five.
// - Shared pins as outputs are open-drain only.
// - Low hardware reset input fully resets device; the code does not reset the clear sync, APB or sensor enable flops.
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module dcps_top #(
  parameter int NUM_DAC = dcps_pkg::DCPS_NUM_DAC,
  parameter int DAC_W = dcps_pkg::DCPS_DAC_W,
  parameter int NUM_IO = dcps_pkg::DCPS_NUM_IO
) (
  // Clock and reset.
  input wire logic MCLK_IN,
  input wire logic RST_IN,
  input wire logic HW_RESET_N_IN,
  // APB slave.
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [dcps_pkg::DCPS_AW-1:0] PADDR_IN,
  input wire logic [dcps_pkg::DCPS_DW-1:0] PWDATA_IN,
  output logic [dcps_pkg::DCPS_DW-1:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // DAC group clear pin.
  input wire logic DAC_GROUP_CLEAR_N_IN,
  // DAC output latches and clear state.
  output logic [NUM_DAC*DAC_W-1:0] DAC_LATCH_OUT,
  output logic CLEAR_STATE_OUT,
  // General-purpose open-drain pins.
  input wire logic [NUM_IO-1:0] GPIO_IN,
  output logic [NUM_IO-1:0] GPIO_OUT,
  output logic [NUM_IO-1:0] GPIO_OE_OUT,
  // Remote sensor enables towards the sensor front end.
  output logic REMOTE_SENSOR_ONE_EN_OUT,
  output logic REMOTE_SENSOR_TWO_EN_OUT
);
  import dcps_pkg::*;

  localparam int HW = $clog2(NUM_DAC);  // Holding index width.
  localparam int IW = DCPS_AW - 2;  // Word index width.
  localparam logic [IW-1:0] HOLD0_IDX = DCPS_OFF_HOLD0[DCPS_AW-1:2];

  // ****************************************************************
  // Synchronous hardware reset.
  // ****************************************************************

  // The active-low reset pin clears registers, holding words, latches, pins and clear state at the next edge.
  logic hw_rst;  // High while a hardware reset is requested.
  assign hw_rst = ~HW_RESET_N_IN;

  // ****************************************************************
  // APB decode.
  // ****************************************************************

  logic [IW-1:0] idx;  // Word index of the access.
  logic [IW-1:0] hold_off;  // Index relative to the first holding word.
  logic [HW-1:0] hold_idx;  // Holding word number.
  logic sel_ctrl;  // Control register hit.
  logic sel_io_out;  // Output level register hit.
  logic sel_io_in;  // Input level register hit.
  logic sel_mask;  // Clear mask register hit.
  logic sel_sync;  // Synchronous-load register hit.
  logic sel_load;  // Load strobe register hit.
  logic sel_code;  // Clear code register hit.
  logic sel_stat;  // Status register hit.
  logic sel_hold;  // Holding register hit.
  logic mapped;  // Any register hit.
  logic acc_done;  // Transfer completes at this edge.
  logic wr_en;  // Write takes effect at this edge.

  assign idx = PADDR_IN[DCPS_AW-1:2];
  assign hold_off = idx - HOLD0_IDX;
  assign hold_idx = hold_off[HW-1:0];
  assign sel_ctrl = PADDR_IN == DCPS_OFF_CTRL;
  assign sel_io_out = PADDR_IN == DCPS_OFF_IO_OUT;
  assign sel_io_in = PADDR_IN == DCPS_OFF_IO_IN;
  assign sel_mask = PADDR_IN == DCPS_OFF_CLR_MASK;
  assign sel_sync = PADDR_IN == DCPS_OFF_SYNC_SEL;
  assign sel_load = PADDR_IN == DCPS_OFF_LOAD;
  assign sel_code = PADDR_IN == DCPS_OFF_CLR_CODE;
  assign sel_stat = PADDR_IN == DCPS_OFF_STATUS;
  assign sel_hold = (PADDR_IN[1:0] == 2'h0) && (idx >= HOLD0_IDX)
                    && (hold_off < IW'(NUM_DAC));
  assign mapped = sel_ctrl | sel_io_out | sel_io_in | sel_mask | sel_sync
                  | sel_load | sel_code | sel_stat | sel_hold;
  assign acc_done = PSEL_IN & PENABLE_IN & PREADY_OUT;
  assign wr_en = acc_done & PWRITE_IN & mapped;

  // ****************************************************************
  // Software registers.
  // ****************************************************************

  logic [1:0] ctrl_q;  // Sensor enables.
  logic [NUM_IO-1:0] io_out_q;  // Zero pulls a pin low.
  logic [NUM_IO-1:0] io_in_q;  // Sampled pin levels.
  logic [NUM_DAC-1:0] mask_q;  // Channels that follow the clear pin.
  logic [NUM_DAC-1:0] sync_sel_q;  // Synchronous-load bit per channel.
  logic [DAC_W-1:0] code_q;  // Predefined clear code.
  logic load_we;  // Load strobe written.
  logic hold_we;  // Holding register written.

  assign load_we = wr_en & sel_load;
  assign hold_we = wr_en & sel_hold;

  // Configuration registers written by software.
  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ctrl_q <= DCPS_CTRL_RST;
      io_out_q <= DCPS_IO_OUT_RST[NUM_IO-1:0];
      mask_q <= DCPS_CLR_MASK_RST[NUM_DAC-1:0];
      sync_sel_q <= DCPS_SYNC_SEL_RST[NUM_DAC-1:0];
      code_q <= DCPS_CLR_CODE_RST[DAC_W-1:0];
    end else if (hw_rst) begin
      ctrl_q <= DCPS_CTRL_RST;
      io_out_q <= DCPS_IO_OUT_RST[NUM_IO-1:0];
      mask_q <= DCPS_CLR_MASK_RST[NUM_DAC-1:0];
      sync_sel_q <= DCPS_SYNC_SEL_RST[NUM_DAC-1:0];
      code_q <= DCPS_CLR_CODE_RST[DAC_W-1:0];
    end else if (wr_en) begin
      if (sel_ctrl) ctrl_q <= PWDATA_IN[1:0];
      if (sel_io_out) io_out_q <= PWDATA_IN[NUM_IO-1:0];
      if (sel_mask) mask_q <= PWDATA_IN[NUM_DAC-1:0];
      if (sel_sync) sync_sel_q <= PWDATA_IN[NUM_DAC-1:0];
      if (sel_code) code_q <= PWDATA_IN[DAC_W-1:0];
    end
  end

  // ****************************************************************
  // Holding data registers.
  // ****************************************************************

  logic [DAC_W-1:0] hold_rdata;  // Registered read of the addressed word.
  logic [NUM_DAC*DAC_W-1:0] hold_words;  // All holding words.

  // Only software writes and the two resets reach the holding words; clear never does.
  dcps_mem #(
    .WORDS(NUM_DAC),
    .W(DAC_W),
    .RST_VAL(DCPS_HOLD_RST)
  ) u_hold (
    .clk_in(MCLK_IN),
    .rst_in(RST_IN),
    .srst_in(hw_rst),
    .we_in(hold_we),
    .waddr_in(hold_idx),
    .wdata_in(PWDATA_IN[DAC_W-1:0]),
    .raddr_in(hold_idx),
    .rdata_out(hold_rdata),
    .words_out(hold_words)
  );

  // ****************************************************************
  // Clear pin synchronisation.
  // ****************************************************************

  logic clr_n_sync;  // Synchronised clear pin, low means clear.
  logic clr_act;  // Clear requested.
  logic clr_leave;  // Clear released at this edge.

  // Two flops keep latch updates glitch-free against the pin.
  dcps_sync #(
    .RST_VAL(1'b1)
  ) u_clr_sync (
    .clk_in(MCLK_IN),
    .rst_in(RST_IN),
    .d_in(DAC_GROUP_CLEAR_N_IN),
    .q_out(clr_n_sync)
  );

  assign clr_act = ~clr_n_sync;
  assign clr_leave = CLEAR_STATE_OUT & ~clr_act;

  // Clear state flag follows the synchronised pin.
  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      CLEAR_STATE_OUT <= 1'b0;
    end else if (hw_rst) begin
      CLEAR_STATE_OUT <= 1'b0;
    end else begin
      CLEAR_STATE_OUT <= clr_act;
    end
  end

  // ****************************************************************
  // DAC output latches, one per channel.
  // ****************************************************************

  for (genvar g = 0; g < NUM_DAC; g++) begin : g_dac
    logic ch_clr;  // Channel held in clear.
    logic ch_leave;  // Channel leaves clear now.
    logic ch_wr;  // Holding register write to this channel, in either mode.
    logic ch_ld;  // Synchronous-mode load strobe for this channel.
    logic [DAC_W-1:0] ch_hold;  // Holding word, newest data first.
    logic [DAC_W-1:0] lat_d;  // Next latch value.

    assign ch_clr = clr_act & mask_q[g];
    assign ch_leave = clr_leave & mask_q[g];
    assign ch_wr = hold_we & (hold_idx == HW'(g));
    assign ch_ld = load_we & PWDATA_IN[g] & sync_sel_q[g];
    assign ch_hold = ch_wr ? PWDATA_IN[DAC_W-1:0] : hold_words[g*DAC_W +: DAC_W];
    assign lat_d = ch_clr ? code_q
                 : ch_leave ? ch_hold
                 : (ch_wr & ~sync_sel_q[g]) ? ch_hold
                 : ch_ld ? ch_hold
                 : DAC_LATCH_OUT[g*DAC_W +: DAC_W];

    // Latch register; clear wins over every normal update.
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
        DAC_LATCH_OUT[g*DAC_W +: DAC_W] <= DCPS_HOLD_RST[DAC_W-1:0];
      end else if (hw_rst) begin
        DAC_LATCH_OUT[g*DAC_W +: DAC_W] <= DCPS_HOLD_RST[DAC_W-1:0];
      end else begin
        DAC_LATCH_OUT[g*DAC_W +: DAC_W] <= lat_d;
      end
    end
  end

  // ****************************************************************
  // Shared sensor and general-purpose pins.
  // ****************************************************************

  logic [NUM_IO-1:0] shared;  // Pin currently owned by a sensor.
  logic [NUM_IO-1:0] oe_d;  // Next output enables.

  // Each pin bit is checked against the two sensor pin pairs.
  for (genvar p = 0; p < NUM_IO; p++) begin : g_pin
    assign shared[p] =
      (ctrl_q[DCPS_CTRL_S1_EN] && (p == DCPS_S1_PIN_LO || p == DCPS_S1_PIN_LO + 1))
      || (ctrl_q[DCPS_CTRL_S2_EN] && (p == DCPS_S2_PIN_LO || p == DCPS_S2_PIN_LO + 1));
    assign oe_d[p] = ~io_out_q[p] & ~shared[p];
  end

  // Pins are only ever pulled low; a high comes from the pull-up.
  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      GPIO_OE_OUT <= '0;
      GPIO_OUT <= '0;
      io_in_q <= '0;
    end else if (hw_rst) begin
      GPIO_OE_OUT <= '0;
      GPIO_OUT <= '0;
      io_in_q <= '0;
    end else begin
      GPIO_OE_OUT <= oe_d;
      GPIO_OUT <= '0;
      io_in_q <= GPIO_IN & ~shared;
    end
  end

  // Sensor enables are shown to the front end.
  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      REMOTE_SENSOR_ONE_EN_OUT <= 1'b0;
      REMOTE_SENSOR_TWO_EN_OUT <= 1'b0;
    end else begin
      REMOTE_SENSOR_ONE_EN_OUT <= ctrl_q[DCPS_CTRL_S1_EN];
      REMOTE_SENSOR_TWO_EN_OUT <= ctrl_q[DCPS_CTRL_S2_EN];
    end
  end

  // ****************************************************************
  // APB answer.
  // ****************************************************************

  logic [DCPS_DW-1:0] rd_mux;  // Read data for the addressed register.
  logic [DCPS_DW-1:0] status_w;  // Status word.

  assign status_w = DCPS_DW'(CLEAR_STATE_OUT) << DCPS_STAT_CLR;
  assign rd_mux = sel_ctrl ? DCPS_DW'(ctrl_q)
                : sel_io_out ? DCPS_DW'(io_out_q)
                : sel_io_in ? DCPS_DW'(io_in_q)
                : sel_mask ? DCPS_DW'(mask_q)
                : sel_sync ? DCPS_DW'(sync_sel_q)
                : sel_code ? DCPS_DW'(code_q)
                : sel_stat ? status_w
                : sel_hold ? DCPS_DW'(hold_rdata)
                : '0;

  // Ready rises in the second access cycle, once holding data settled.
  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      PREADY_OUT <= 1'b0;
      PSLVERR_OUT <= 1'b0;
      PRDATA_OUT <= '0;
    end else begin
      PREADY_OUT <= PSEL_IN & PENABLE_IN & ~PREADY_OUT;
      PSLVERR_OUT <= PSEL_IN & PENABLE_IN & ~PREADY_OUT & ~mapped;
      // Read data stands only in the ready cycle and is zero after it.
      PRDATA_OUT <= (PSEL_IN & PENABLE_IN & ~PWRITE_IN & ~PREADY_OUT) ? rd_mux : '0;
    end
  end

endmodule : dcps_top
`default_nettype wire

// ==== sim/dcps_sva.sv ====
// Assertion checker for the DAC clear and pin-share block.
`timescale 1ns/1ns
`default_nettype none
module dcps_sva #(
  parameter int NUM_DAC = 12,
  parameter int DAC_W = 12,
  parameter int NUM_IO = 8
) (
  // Clock and resets.
  input wire logic MCLK_IN,
  input wire logic RST_IN,
  input wire logic HW_RESET_N_IN,
  // APB slave side.
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  // Clear pin and DAC side.
  input wire logic DAC_GROUP_CLEAR_N_IN,
  input wire logic [NUM_DAC*DAC_W-1:0] DAC_LATCH_OUT,
  input wire logic CLEAR_STATE_OUT,
  // Pins and sensor enables.
  input wire logic [NUM_IO-1:0] GPIO_OUT,
  input wire logic [NUM_IO-1:0] GPIO_OE_OUT,
  input wire logic REMOTE_SENSOR_ONE_EN_OUT,
  input wire logic REMOTE_SENSOR_TWO_EN_OUT
);
  // ****************************************************************
  // Properties.
  // ****************************************************************
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (RST_IN || !HW_RESET_N_IN);

  // The pins are only ever pulled low, never driven high.
  a_gpio_low_only: assert property (GPIO_OUT == '0)
    else $error("pin data driven high");
  a_sensor_two_owns: assert property (
    REMOTE_SENSOR_TWO_EN_OUT && $past(REMOTE_SENSOR_TWO_EN_OUT) |-> GPIO_OE_OUT[7:6] == 2'b00)
    else $error("sensor two pins pulled");
  a_sensor_one_owns: assert property (
    REMOTE_SENSOR_ONE_EN_OUT && $past(REMOTE_SENSOR_ONE_EN_OUT) |-> GPIO_OE_OUT[5:4] == 2'b00)
    else $error("sensor one pins pulled");
  // The clear pin passes two flops, then the state flop follows.
  a_clear_enter: assert property ($fell(DAC_GROUP_CLEAR_N_IN) |-> ##3 CLEAR_STATE_OUT)
    else $error("clear state late");
  a_clear_leave: assert property ($rose(DAC_GROUP_CLEAR_N_IN) |-> ##3 !CLEAR_STATE_OUT)
    else $error("clear state not left");
  a_clear_cause: assert property ($rose(CLEAR_STATE_OUT) |-> !$past(DAC_GROUP_CLEAR_N_IN, 3))
    else $error("clear state without synced pin");
  a_apb_one_wait: assert property (PSEL_IN && !PENABLE_IN |=> !PREADY_OUT ##1 PREADY_OUT)
    else $error("ready not in second access cycle");
  a_ready_pulse: assert property (PREADY_OUT |=> !PREADY_OUT)
    else $error("ready longer than one cycle");
  a_error_ready: assert property (PSLVERR_OUT |-> PREADY_OUT)
    else $error("error without ready");
  a_rdata_idle: assert property (!PREADY_OUT |-> PRDATA_OUT == 32'h0000_0000)
    else $error("read data not idle");
  // A hardware reset clears latches, pins and the clear state.
  a_hw_reset_clears: assert property (disable iff (RST_IN) !HW_RESET_N_IN
    |=> DAC_LATCH_OUT == '0 && GPIO_OE_OUT == '0 && !CLEAR_STATE_OUT)
    else $error("hardware reset left state");
  c_clear_seen: cover property ($rose(CLEAR_STATE_OUT));
  c_error_seen: cover property (PSLVERR_OUT);
  c_sensor_two: cover property (REMOTE_SENSOR_TWO_EN_OUT);
endmodule : dcps_sva
`default_nettype wire

// ==== sim/tb_top.sv ====
// Self-checking testbench for the DAC clear and pin-share block.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import dcps_pkg::*;
  logic clk = 1'b0;  // Bench clock.
  logic rst = 1'b1;  // Asynchronous reset.
  logic hw_n = 1'b1;  // Hardware reset, active low.
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, clr_n = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, perr, cstate, en1, en2;
  logic [143:0] latch;
  logic [7:0] gout, goe, gin, own;
  logic [31:0] r;
  logic e;
  int err_total = 0;
  int n_compared = 0;
  logic [7:0] offs [8] = '{DCPS_OFF_CTRL, DCPS_OFF_IO_OUT, DCPS_OFF_CLR_MASK, DCPS_OFF_SYNC_SEL,
    DCPS_OFF_LOAD, DCPS_OFF_CLR_CODE, DCPS_OFF_STATUS, DCPS_OFF_HOLD0};
  logic [31:0] rstv [8] = '{32'h0000_0000, 32'h0000_00FF, 32'h0000_0FFF, 32'h0000_0000,
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};

  always #20 clk = ~clk;
  // Pull-up on every pin: high unless the device pulls it low.
  assign gin = ~goe;

  dcps_top u_dcps_top (.MCLK_IN(clk), .RST_IN(rst), .HW_RESET_N_IN(hw_n), .PSEL_IN(psel),
    .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(perr),
    .DAC_GROUP_CLEAR_N_IN(clr_n), .DAC_LATCH_OUT(latch), .CLEAR_STATE_OUT(cstate),
    .GPIO_IN(gin), .GPIO_OUT(gout), .GPIO_OE_OUT(goe),
    .REMOTE_SENSOR_ONE_EN_OUT(en1), .REMOTE_SENSOR_TWO_EN_OUT(en2));

  // ****************************************************************
  // Tasks.
  // ****************************************************************
  task report_and_stop;
    if (err_total == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  // Compares one value and reports a mismatch at once.
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // One APB transfer; waits for ready under a bound, then idles one cycle.
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1; pen <= 1'b0; pwr <= wr; paddr <= a; pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    r = prdata;
    e = perr;
    psel <= 1'b0; pen <= 1'b0;
    if (pready !== 1'b1) begin
      err_total++;
      $display("CHECK FAILED at %0t: no ready", $time);
      report_and_stop();
    end
    @(posedge clk);
  endtask : apb

  // Reads a register and compares data and error flag.
  task rd(input logic [7:0] a, input logic [31:0] exp, input logic ee);
    apb(1'b0, a, 32'h0000_0000);
    chk(r, exp, "read data");
    chk({31'h0, e}, {31'h0, ee}, "error flag");
  endtask : rd

  // Checks one DAC latch.
  task lat(input int n, input logic [11:0] exp);
    chk({20'h0, latch[n*12 +: 12]}, {20'h0, exp}, "latch");
  endtask : lat

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 8; i++) rd(offs[i], rstv[i], 1'b0);
    rd(8'h30, 32'h0000_0000, 1'b1);
    apb(1'b1, 8'h30, 32'h0000_FFFF);
    chk({31'h0, e}, 32'h0000_0001, "write error");
    apb(1'b1, DCPS_OFF_IO_IN, 32'h0000_0000);
    rd(DCPS_OFF_IO_IN, 32'h0000_00FF, 1'b0);
    // Normal path: direct update and synchronous load.
    apb(1'b1, DCPS_OFF_HOLD0 + 8'h0C, 32'h0000_05A5);
    lat(3, 12'h5A5);
    apb(1'b1, DCPS_OFF_SYNC_SEL, 32'h0000_0010);
    apb(1'b1, DCPS_OFF_HOLD0 + 8'h10, 32'h0000_0123);
    lat(4, 12'h000);
    apb(1'b1, DCPS_OFF_LOAD, 32'h0000_0010);
    lat(4, 12'h123);
    apb(1'b1, DCPS_OFF_HOLD0 + 8'h14, 32'h0000_0777);
    // Clear on channels three and four only.
    apb(1'b1, DCPS_OFF_CLR_MASK, 32'h0000_0018);
    apb(1'b1, DCPS_OFF_CLR_CODE, 32'h0000_0ABC);
    clr_n <= 1'b0;
    repeat (6) @(posedge clk);
    lat(3, 12'hABC);
    lat(4, 12'hABC);
    lat(5, 12'h777);
    rd(DCPS_OFF_STATUS, 32'h0000_0001, 1'b0);
    apb(1'b1, DCPS_OFF_HOLD0 + 8'h0C, 32'h0000_0111);
    lat(3, 12'hABC);
    rd(DCPS_OFF_HOLD0 + 8'h0C, 32'h0000_0111, 1'b0);
    rd(DCPS_OFF_HOLD0 + 8'h10, 32'h0000_0123, 1'b0);
    clr_n <= 1'b1;
    repeat (6) @(posedge clk);
    lat(3, 12'h111);
    lat(4, 12'h123);
    chk({31'h0, cstate}, 32'h0000_0000, "clear state");
    apb(1'b1, DCPS_OFF_HOLD0 + 8'h0C, 32'h0000_0222);
    lat(3, 12'h222);
    // Pin sharing for every sensor enable combination.
    apb(1'b1, DCPS_OFF_IO_OUT, 32'h0000_00A0);
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, DCPS_OFF_CTRL, 32'(c));
      repeat (2) @(posedge clk);
      own = (c[0] ? 8'h30 : 8'h00) | (c[1] ? 8'hC0 : 8'h00);
      chk({24'h0, goe}, {24'h0, ~8'hA0 & ~own}, "pin enables");
      chk({24'h0, gout}, 32'h0000_0000, "pin data");
      chk({30'h0, en2, en1}, 32'(c), "sensor enables");
      rd(DCPS_OFF_IO_IN, {24'h0, 8'hA0 & ~own}, 1'b0);
    end
    // Hardware reset mid-run.
    hw_n <= 1'b0;
    repeat (2) @(posedge clk);
    hw_n <= 1'b1;
    @(posedge clk);
    chk({31'h0, |latch}, 32'h0000_0000, "latches after reset");
    chk({24'h0, goe}, 32'h0000_0000, "pins after reset");
    rd(DCPS_OFF_HOLD0 + 8'h0C, 32'h0000_0000, 1'b0);
    rd(DCPS_OFF_IO_OUT, 32'h0000_00FF, 1'b0);
    report_and_stop();
  end

  // Cuts a hang short.
  initial begin
    #2_000_000;
    err_total++;
    $display("CHECK FAILED at %0t: run too long", $time);
    report_and_stop();
  end
endmodule : tb_top

bind dcps_top dcps_sva #(.NUM_DAC(NUM_DAC), .DAC_W(DAC_W), .NUM_IO(NUM_IO)) u_dcps_sva (
  .MCLK_IN(MCLK_IN), .RST_IN(RST_IN), .HW_RESET_N_IN(HW_RESET_N_IN), .PSEL_IN(PSEL_IN),
  .PENABLE_IN(PENABLE_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
  .PSLVERR_OUT(PSLVERR_OUT), .DAC_GROUP_CLEAR_N_IN(DAC_GROUP_CLEAR_N_IN),
  .DAC_LATCH_OUT(DAC_LATCH_OUT), .CLEAR_STATE_OUT(CLEAR_STATE_OUT), .GPIO_OUT(GPIO_OUT),
  .GPIO_OE_OUT(GPIO_OE_OUT), .REMOTE_SENSOR_ONE_EN_OUT(REMOTE_SENSOR_ONE_EN_OUT),
  .REMOTE_SENSOR_TWO_EN_OUT(REMOTE_SENSOR_TWO_EN_OUT));
`default_nettype wire
